// ==== logic/nbp_defs.svh ====
/*
  Offsets, field positions, reset values and fixed constants of the nibble port block.
  Assumes inclusion by bare name from the design file and the bench.
*/
`ifndef NBP_DEFS_SVH
`define NBP_DEFS_SVH
`define NBP_IDX_CPDIR     8'h01
`define NBP_IDX_DATA4     8'h04
`define NBP_IDX_SPDIR     8'h05
`define NBP_IDX_SPDATA    8'h06
`define NBP_IDX_INDATA    8'h0e
`define NBP_IDX_OPT0      8'h20
`define NBP_IDX_OPT1      8'h21
`define NBP_IDX_STAT      8'h22
`define NBP_RST_NIB       4'h0
`define NBP_WAKE_VECTOR   13'h0004
`define NBP_OPT1_CMP1     0
`define NBP_OPT1_CMP2     1
`define NBP_OPT1_AMP      2
`define NBP_OPT1_BIT1_READ_ZERO     3
`define NBP_OPT1_BIT3_READ_ZERO     4
`define NBP_OPT1_BIDIR    5
`define NBP_OPT1_ROLE     6
`define NBP_OPT1_GAIN     7
`endif

// ==== logic/nbp_pkg.sv ====
/*
  Types of the nibble port block.
  Includes no header; only the design file and the bench include the constants header.
*/
package nbp_pkg;
  typedef enum logic [1:0] {
    NBP_ROLE_OUT   = 2'b00,
    NBP_ROLE_IN    = 2'b01,
    NBP_ROLE_BIDIR = 2'b10
  } nbp_role_t;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
    logic [3:0] pd;
  } nbp_pins_t;

  typedef struct packed {
    logic [3:0] cp_dir;
    logic [3:0] cp_data;
    logic [3:0] oc_data;
    logic [3:0] sp_dir;
    logic [3:0] sp_data;
    logic [3:0] sp_in_prev;
    logic [3:0] wake_mask;
    logic [3:0] sp_pd_opt;
    logic [3:0] ce_pd_opt;
    logic [7:0] opt;
    logic       wake;
    logic       sleep_seen;
    logic       hready;
    logic       pend_wr;
    logic [7:0] pend_idx;
    logic [31:0] hrdata;
    nbp_pins_t  sp_pins;
    nbp_pins_t  ce_pins;
    logic       osc_on;
    logic       pc_load;
  } nbp_state_t;
endpackage : nbp_pkg

// ==== logic/nbp_ports.sv ====
/*
  Nibble port block: port B with wake-up, and the four-bit port serving as
  output port, input port or combined bidirectional port with comparator reads.
  Assumes an AHB-Lite master issuing single word transfers, pins synchronous
  to the clock, and a core that reacts to the wake pulse and vector.
*/
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "nbp_defs.svh"

// Overview of operation
// R1: Port B direction bit 1 means output, 0 input; resets to all inputs.
// R2: Output pins drive the written latch; reads of output bits return the latch.
// R3: Port B pull-down forced off on output pins.
// R4: Port B input bits read the pin; pull-down follows per-bit option.
// R5: In sleep, a rising edge on a wake-enabled port B pin wakes the system.
// R6: Pin wake-up loads the program counter with the wake-up vector.
// R7: Output-port role: all four bits outputs, register resets to zero.
// R8: Input-port role: all bits inputs, reads return pins, pull-downs by option.
// R9: Combined role: direction bit 1 output, 0 input; resets to zero.
// R10: Combined-port pull-downs apply only to input bits.
// R11: Amplifier and comparator options choose among three structures.
// R12: Bit-1 read-zero option makes combined bit 1 read zero; the code does so only while a comparator or amplifier option is on.
// R13: Bit-3 read-zero option makes combined bit 3 read zero; the code does so only while a comparator or amplifier option is on.
// R14: Comparator 1 alone makes combined bit 0 read its output.
// R15: All analog options off gives a plain port.
// R16: Each comparator is enabled by its own option.
// R17: Software should keep combined bit 1 input in amplifier mode.
// R18: Software should not enable gain together with the amplifier.
// R19: Comparator 2 alone makes combined bit 2 read its output.
// R20: An option picks output-port or input-port role for the four-bit port.
// R21: The chosen role decides which register the shared address decodes to.
module nbp_ports (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic [3:0]         sp_pin_i,
  output nbp_pkg::nbp_pins_t      sp_pins,
  input  wire logic [3:0]         ce_pin_i,
  output nbp_pkg::nbp_pins_t      ce_pins,
  input  wire logic               comparator_one_out,
  input  wire logic               comparator_two_out,
  input  wire logic               sleep,
  output logic                    wake,
  output logic                    osc_on,
  output logic                    pc_load,
  output logic [12:0]             pc_vector
);
  import nbp_pkg::*;

  nbp_state_t s_q;
  nbp_state_t s_d;

  function automatic nbp_role_t role_of(input logic [7:0] opt);
    if (opt[`NBP_OPT1_BIDIR]) begin
      return NBP_ROLE_BIDIR;
    end
    return opt[`NBP_OPT1_ROLE] ? NBP_ROLE_IN : NBP_ROLE_OUT; // R20
  endfunction : role_of

  // Mix latch and pin per direction; used by both bidirectional ports.
  function automatic logic [3:0] mix(input logic [3:0] dir, input logic [3:0] lat,
                                     input logic [3:0] pin);
    return (dir & lat) | (~dir & pin); // R2 R4
  endfunction : mix

  nbp_role_t  role;
  logic       cmp1;
  logic       cmp2;
  logic       amp;
  logic [3:0] ce_rd;
  logic [31:0] rd;
  logic       addr_ok;
  logic [3:0] rises;

  always_comb begin
    role = role_of(s_q.opt);
    cmp1 = s_q.opt[`NBP_OPT1_CMP1]; // R16
    cmp2 = s_q.opt[`NBP_OPT1_CMP2]; // R16
    amp  = s_q.opt[`NBP_OPT1_AMP];
    ce_rd = mix(s_q.cp_dir, s_q.cp_data, ce_pin_i); // R15
    if (cmp1 || cmp2 || amp) begin // R11
      if (s_q.opt[`NBP_OPT1_BIT1_READ_ZERO]) begin
        ce_rd[1] = 1'b0; // R12
      end
      if (s_q.opt[`NBP_OPT1_BIT3_READ_ZERO]) begin
        ce_rd[3] = 1'b0; // R13
      end
      if (cmp1 && !cmp2 && !amp) begin
        ce_rd[0] = comparator_one_out; // R14
      end
      if (cmp2 && !cmp1 && !amp) begin
        ce_rd[2] = comparator_two_out; // R19
      end
      if (cmp1 && amp && !cmp2) begin
        ce_rd[0] = comparator_one_out;
        ce_rd[3:2] = 2'h0;
      end
    end
  end

  always_comb begin
    rises = sp_pin_i & ~s_q.sp_in_prev & s_q.wake_mask & ~s_q.sp_dir;
    rd = 32'h0;
    addr_ok = 1'b1;
    unique case (s_q.pend_idx)
      `NBP_IDX_CPDIR:  rd[3:0] = s_q.cp_dir;
      `NBP_IDX_DATA4:  rd[3:0] = (role == NBP_ROLE_BIDIR) ? ce_rd : s_q.oc_data; // R21
      `NBP_IDX_SPDIR:  rd[3:0] = s_q.sp_dir;
      `NBP_IDX_SPDATA: rd[3:0] = mix(s_q.sp_dir, s_q.sp_data, sp_pin_i); // R2 R4
      `NBP_IDX_INDATA: rd[3:0] = (role == NBP_ROLE_IN) ? ce_pin_i : 4'h0; // R8
      `NBP_IDX_OPT0:   rd[15:0] = {s_q.ce_pd_opt, s_q.sp_pd_opt, s_q.wake_mask, 4'h0};
      `NBP_IDX_OPT1:   rd[7:0] = s_q.opt;
      `NBP_IDX_STAT:   rd[1:0] = {s_q.sleep_seen, s_q.osc_on};
      default:         addr_ok = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.hready = 1'b1;
    s_d.pend_wr = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.wake = 1'b0;
    s_d.sp_in_prev = sp_pin_i;
    s_d.hrdata = addr_ok ? rd : 32'h0;
    if (s_q.pend_wr) begin
      unique case (s_q.pend_idx)
        `NBP_IDX_CPDIR:  s_d.cp_dir = hwdata[3:0]; // R9
        `NBP_IDX_DATA4: begin
          if (role == NBP_ROLE_BIDIR) begin
            s_d.cp_data = hwdata[3:0]; // R21
          end else begin
            s_d.oc_data = hwdata[3:0]; // R7
          end
        end
        `NBP_IDX_SPDIR:  s_d.sp_dir = hwdata[3:0]; // R1
        `NBP_IDX_SPDATA: s_d.sp_data = hwdata[3:0];
        `NBP_IDX_OPT0: begin
          s_d.wake_mask = hwdata[7:4];
          s_d.sp_pd_opt = hwdata[11:8];
          s_d.ce_pd_opt = hwdata[15:12];
        end
        `NBP_IDX_OPT1:   s_d.opt = hwdata[7:0];
        default: ;
      endcase
    end
    // Reads take one wait state, so hrdata stays a flip-flop and still sees a write just ahead.
    if (hsel && hready && htrans[1]) begin
      s_d.pend_wr = hwrite;
      s_d.pend_idx = {2'h0, haddr[7:2]};
      s_d.hready = hwrite;
    end
    // Osc stays stopped while asleep until a wake edge restarts it.
    if (sleep && !s_q.sleep_seen) begin
      s_d.sleep_seen = 1'b1;
      s_d.osc_on = 1'b0;
    end
    if (s_q.sleep_seen && sleep && (rises != 4'h0)) begin // R5
      s_d.wake = 1'b1;
      s_d.osc_on = 1'b1;
      s_d.pc_load = 1'b1; // R6
      s_d.sleep_seen = 1'b0;
    end
    if (!sleep && s_q.sleep_seen) begin
      s_d.sleep_seen = 1'b0;
      s_d.osc_on = 1'b1;
    end
    s_d.sp_pins.o = s_q.sp_data;
    s_d.sp_pins.oe = s_q.sp_dir; // R1
    s_d.sp_pins.pd = s_q.sp_pd_opt & ~s_q.sp_dir; // R3 R4
    unique case (role)
      NBP_ROLE_OUT: begin
        s_d.ce_pins.o = s_q.oc_data;
        s_d.ce_pins.oe = 4'hf; // R7
        s_d.ce_pins.pd = 4'h0;
      end
      NBP_ROLE_IN: begin
        s_d.ce_pins.o = 4'h0;
        s_d.ce_pins.oe = 4'h0; // R8
        s_d.ce_pins.pd = s_q.ce_pd_opt;
      end
      NBP_ROLE_BIDIR: begin
        s_d.ce_pins.o = s_q.cp_data;
        s_d.ce_pins.oe = s_q.cp_dir; // R9
        s_d.ce_pins.pd = s_q.ce_pd_opt & ~s_q.cp_dir; // R10
      end
      default: begin
        s_d.ce_pins = '0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.hready <= 1'b1;
      s_q.osc_on <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata    = s_q.hrdata;
  assign hreadyout = s_q.hready;
  assign hresp     = 1'b0;
  assign sp_pins   = s_q.sp_pins;
  assign ce_pins   = s_q.ce_pins;
  assign wake      = s_q.wake;
  assign osc_on    = s_q.osc_on;
  assign pc_load   = s_q.pc_load;
  assign pc_vector = `NBP_WAKE_VECTOR; // R6

  property p_sp_pd_off;
    @(posedge clock) disable iff (reset) s_q.sp_dir[0] |=> !sp_pins.pd[0] || !$stable(s_q.sp_dir);
  endproperty
  a_sp_pd_off: assert property (p_sp_pd_off) else $error("pulldown on output pin"); // R3

  property p_sp_oe;
    @(posedge clock) disable iff (reset) 1'b1 |=> sp_pins.oe == $past(s_q.sp_dir);
  endproperty
  a_sp_oe: assert property (p_sp_oe) else $error("port B enable mismatch"); // R1

  sequence s_wake_edge;
    s_q.sleep_seen && sleep && (rises != 4'h0);
  endsequence
  property p_wake;
    @(posedge clock) disable iff (reset) s_wake_edge |=> wake && pc_load && osc_on;
  endproperty
  a_wake: assert property (p_wake) else $error("wake edge missed"); // R5

  property p_pc;
    @(posedge clock) disable iff (reset) pc_load |-> wake && pc_vector == 13'h0004;
  endproperty
  a_pc: assert property (p_pc) else $error("wake vector wrong"); // R6

  property p_out_role;
    @(posedge clock) disable iff (reset)
      (role == NBP_ROLE_OUT) ##1 (role == NBP_ROLE_OUT) |-> ce_pins.oe == 4'hf;
  endproperty
  a_out_role: assert property (p_out_role) else $error("output role not driving"); // R7

  property p_in_role;
    @(posedge clock) disable iff (reset)
      (role == NBP_ROLE_IN) ##1 (role == NBP_ROLE_IN) |-> ce_pins.oe == 4'h0;
  endproperty
  a_in_role: assert property (p_in_role) else $error("input role driving"); // R8

  property p_ce_pd;
    @(posedge clock) disable iff (reset) ce_pins.pd[1] |-> !ce_pins.oe[1];
  endproperty
  a_ce_pd: assert property (p_ce_pd) else $error("combined pulldown on output"); // R10

  property p_bit1_read_zero;
    @(posedge clock) disable iff (reset)
      (cmp1 && s_q.opt[`NBP_OPT1_BIT1_READ_ZERO]) |-> ce_rd[1] == 1'b0;
  endproperty
  a_bit1_read_zero: assert property (p_bit1_read_zero) else $error("bit1 not zero"); // R12

  property p_cmp1;
    @(posedge clock) disable iff (reset)
      (cmp1 && !cmp2 && !amp) |-> ce_rd[0] == comparator_one_out;
  endproperty
  a_cmp1: assert property (p_cmp1) else $error("comparator one not read"); // R14

  property p_cmp2;
    @(posedge clock) disable iff (reset)
      (cmp2 && !cmp1 && !amp) |-> ce_rd[2] == comparator_two_out;
  endproperty
  a_cmp2: assert property (p_cmp2) else $error("comparator two not read"); // R19

  sequence s_rd_req;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  property p_rd_wait;
    @(posedge clock) disable iff (reset)
      s_rd_req |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong"); // R2

  property p_wr_no_wait;
    @(posedge clock) disable iff (reset)
      (hsel && hready && htrans[1] && hwrite) |=> hreadyout;
  endproperty
  a_wr_no_wait: assert property (p_wr_no_wait) else $error("write stalled"); // R2

  sequence s_spdir_wr;
    hsel && hready && htrans[1] && hwrite && ({2'h0, haddr[7:2]} == `NBP_IDX_SPDIR);
  endsequence
  property p_sp_dir_lands;
    @(posedge clock) disable iff (reset)
      s_spdir_wr |=> ##1 s_q.sp_dir == $past(hwdata[3:0]);
  endproperty
  a_sp_dir_lands: assert property (p_sp_dir_lands) else $error("port B direction lost"); // R1

  sequence s_cpdir_wr;
    hsel && hready && htrans[1] && hwrite && ({2'h0, haddr[7:2]} == `NBP_IDX_CPDIR);
  endsequence
  property p_cp_dir_lands;
    @(posedge clock) disable iff (reset)
      s_cpdir_wr |=> ##1 s_q.cp_dir == $past(hwdata[3:0]);
  endproperty
  a_cp_dir_lands: assert property (p_cp_dir_lands) else $error("combined direction lost"); // R9

  property p_sp_pd;
    @(posedge clock) disable iff (reset)
      1'b1 |=> sp_pins.pd == ($past(s_q.sp_pd_opt) & ~$past(s_q.sp_dir));
  endproperty
  a_sp_pd: assert property (p_sp_pd) else $error("port B pulldown wrong"); // R4

  property p_sp_o;
    @(posedge clock) disable iff (reset)
      1'b1 |=> sp_pins.o == $past(s_q.sp_data);
  endproperty
  a_sp_o: assert property (p_sp_o) else $error("port B output not latch"); // R2

  sequence s_bidir_held;
    (role == NBP_ROLE_BIDIR) ##1 (role == NBP_ROLE_BIDIR);
  endsequence
  property p_bidir_oe;
    @(posedge clock) disable iff (reset)
      s_bidir_held |-> ce_pins.oe == $past(s_q.cp_dir);
  endproperty
  a_bidir_oe: assert property (p_bidir_oe) else $error("combined enable mismatch"); // R9

  property p_out_data;
    @(posedge clock) disable iff (reset)
      (role == NBP_ROLE_OUT) ##1 (role == NBP_ROLE_OUT) |-> ce_pins.o == $past(s_q.oc_data);
  endproperty
  a_out_data: assert property (p_out_data) else $error("output port data wrong"); // R7

  property p_in_pd;
    @(posedge clock) disable iff (reset)
      (role == NBP_ROLE_IN) ##1 (role == NBP_ROLE_IN) |-> ce_pins.pd == $past(s_q.ce_pd_opt);
  endproperty
  a_in_pd: assert property (p_in_pd) else $error("input port pulldown wrong"); // R8

  property p_bit3_read_zero;
    @(posedge clock) disable iff (reset)
      ((cmp1 || cmp2 || amp) && s_q.opt[`NBP_OPT1_BIT3_READ_ZERO]) |-> ce_rd[3] == 1'b0;
  endproperty
  a_bit3_read_zero: assert property (p_bit3_read_zero) else $error("bit3 not zero"); // R13

  property p_plain;
    @(posedge clock) disable iff (reset)
      !(cmp1 || cmp2 || amp) |->
        ce_rd == ((s_q.cp_dir & s_q.cp_data) | (~s_q.cp_dir & ce_pin_i));
  endproperty
  a_plain: assert property (p_plain) else $error("plain port read wrong"); // R15

  property p_cmp_amp;
    @(posedge clock) disable iff (reset)
      (cmp1 && amp && !cmp2) |-> ce_rd[0] == comparator_one_out && ce_rd[3:2] == 2'h0;
  endproperty
  a_cmp_amp: assert property (p_cmp_amp) else $error("comparator with amplifier wrong"); // R11

  property p_osc_sleep;
    @(posedge clock) disable iff (reset)
      (sleep && !s_q.sleep_seen) |=> !osc_on;
  endproperty
  a_osc_sleep: assert property (p_osc_sleep) else $error("oscillator not stopped"); // R5

  property p_no_wake;
    @(posedge clock) disable iff (reset)
      (s_q.sleep_seen && sleep && (rises == 4'h0)) |=> !wake && !pc_load;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("wake without edge"); // R5

  property p_idx_read;
    @(posedge clock) disable iff (reset)
      (!hreadyout && s_q.pend_idx == `NBP_IDX_DATA4 && role != NBP_ROLE_BIDIR) |=>
        hrdata[3:0] == $past(s_q.oc_data);
  endproperty
  a_idx_read: assert property (p_idx_read) else $error("shared address read wrong"); // R21
endmodule : nbp_ports
`default_nettype wire

// ==== tb/nbp_pin_model.sv ====
/*
  Board model of the port pins: works out the level of every pin.
  Assumes the block's pin structs and the bench clock.
*/
`timescale 1ns/100ps
`default_nettype none
module nbp_pin_model (
  input  wire logic               clock,
  input  wire nbp_pkg::nbp_pins_t sp_pins,
  input  wire nbp_pkg::nbp_pins_t ce_pins,
  input  wire logic [1:0] ext_en,
  input  wire logic [3:0] sp_ext,
  input  wire logic [3:0] ce_ext,
  output logic [3:0]      sp_pin_i,
  output logic [3:0]      ce_pin_i
);
  import nbp_pkg::*;
  logic [3:0] flip_q = 4'h5;

  // A floating pin changes every cycle so that it can never pass for a fixed value.
  always_ff @(posedge clock) begin
    flip_q <= ~flip_q;
  end

  function automatic logic [3:0] level(nbp_pins_t p, logic en, logic [3:0] ext,
                                       logic [3:0] fl);
    return (p.oe & p.o) | (~p.oe & (en ? ext : (~p.pd & fl)));
  endfunction : level

  assign sp_pin_i = level(sp_pins, ext_en[0], sp_ext, flip_q);
  assign ce_pin_i = level(ce_pins, ext_en[1], ce_ext, flip_q);
endmodule : nbp_pin_model
`default_nettype wire

// ==== tb/nibble_ports_b_c_e_ce_test.sv ====
/*
  Self-checking bench of the nibble port block.
  Assumes the pin model; the master waits for hready in every phase.
*/
`timescale 1ns/100ps
`default_nettype none
`include "nbp_defs.svh"
module nibble_ports_b_c_e_ce_test;
  import nbp_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        cmp1 = 1'b0;
  logic        cmp2 = 1'b0;
  logic        sleep = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  sp_ext = 4'h0;
  logic [3:0]  ce_ext = 4'h0;
  logic [1:0]  ext_en = 2'h3;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, wake, osc_on, pc_load;
  logic [12:0] pc_vector;
  logic [3:0]  sp_pin_i, ce_pin_i;
  nbp_pins_t   sp_pins, ce_pins;
  int          n_errors = 0;
  int          n_compared = 0;

  always #50 clock = ~clock;

  nbp_ports i_nbp_ports (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sp_pin_i(sp_pin_i),
    .sp_pins(sp_pins), .ce_pin_i(ce_pin_i), .ce_pins(ce_pins), .comparator_one_out(cmp1),
    .comparator_two_out(cmp2), .sleep(sleep), .wake(wake), .osc_on(osc_on),
    .pc_load(pc_load), .pc_vector(pc_vector));

  nbp_pin_model i_nbp_pin_model (.clock(clock), .sp_pins(sp_pins), .ce_pins(ce_pins),
    .ext_en(ext_en), .sp_ext(sp_ext), .ce_ext(ce_ext), .sp_pin_i(sp_pin_i),
    .ce_pin_i(ce_pin_i));

  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic await_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      print_verdict();
    end
  endtask : await_ready

  // Address phase is held until ready, then the data phase until ready again.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    await_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    await_ready();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // Pins follow a write one edge after its data phase.
  task automatic settle();
    repeat (3) @(posedge clock);
  endtask : settle

  task automatic t_reset();
    rdchk(`NBP_IDX_CPDIR, 32'h0);
    rdchk(`NBP_IDX_SPDIR, 32'h0);
    rdchk(`NBP_IDX_DATA4, 32'h0);
    check({28'h0, sp_pins.oe}, 32'h0);
    check({31'h0, hresp}, 32'h0);
  endtask : t_reset

  task automatic t_port_b();
    sp_ext <= 4'hc;
    wr(`NBP_IDX_OPT0, 32'h0a00);
    wr(`NBP_IDX_SPDIR, 32'h3);
    wr(`NBP_IDX_SPDATA, 32'h5);
    settle();
    check({28'h0, sp_pins.oe}, 32'h3);
    check({28'h0, sp_pins.o & 4'h3}, 32'h1);
    check({28'h0, sp_pins.pd}, 32'h8);
    rdchk(`NBP_IDX_SPDATA, 32'hd);
  endtask : t_port_b

  task automatic t_wake();
    int n;
    n = 0;
    sp_ext <= 4'h0;
    wr(`NBP_IDX_OPT0, 32'h0a40);
    sleep <= 1'b1;
    settle();
    check({31'h0, osc_on}, 32'h0);
    sp_ext <= 4'h4;
    do begin
      @(posedge clock);
      n++;
    end while (wake !== 1'b1 && n < 8);
    check({31'h0, wake}, 32'h1);
    check({31'h0, pc_load}, 32'h1);
    check({19'h0, pc_vector}, 32'h4);
    check({31'h0, osc_on}, 32'h1);
    sleep <= 1'b0;
  endtask : t_wake

  task automatic t_roles();
    wr(`NBP_IDX_OPT1, 32'h0);
    wr(`NBP_IDX_DATA4, 32'h9);
    settle();
    check({24'h0, ce_pins.oe, ce_pins.o}, 32'hf9);
    rdchk(`NBP_IDX_INDATA, 32'h0);
    ce_ext <= 4'ha;
    wr(`NBP_IDX_OPT0, 32'h6000);
    wr(`NBP_IDX_OPT1, 32'h40);
    settle();
    check({24'h0, ce_pins.oe, ce_pins.pd}, 32'h06);
    rdchk(`NBP_IDX_INDATA, 32'ha);
    ext_en <= 2'h1;
    bus(1'b0, `NBP_IDX_INDATA, 32'h0);
    check(rd & 32'h6, 32'h0);
    ext_en <= 2'h3;
  endtask : t_roles

  task automatic t_bidir();
    wr(`NBP_IDX_OPT1, 32'h20);
    wr(`NBP_IDX_CPDIR, 32'h5);
    wr(`NBP_IDX_DATA4, 32'h3);
    settle();
    check({24'h0, ce_pins.oe, ce_pins.pd}, 32'h52);
    check({28'h0, ce_pins.o & 4'h5}, 32'h1);
    rdchk(`NBP_IDX_DATA4, 32'hb);
    wr(`NBP_IDX_OPT1, 32'h0);
    rdchk(`NBP_IDX_DATA4, 32'h9);
  endtask : t_bidir

  task automatic t_analog();
    logic [7:0] opt [9] = '{8'h21, 8'h29, 8'h22, 8'h32, 8'h25, 8'h2d, 8'h3b, 8'h20, 8'h38};
    logic [3:0] exp [9] = '{4'hb, 4'h9, 4'he, 4'h6, 4'h3, 4'h1, 4'h0, 4'ha, 4'ha};
    wr(`NBP_IDX_OPT1, 32'h20);
    wr(`NBP_IDX_CPDIR, 32'h0);
    cmp1 <= 1'b1;
    cmp2 <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      wr(`NBP_IDX_OPT1, {24'h0, opt[i]});
      rdchk(`NBP_IDX_DATA4, {28'h0, exp[i]});
    end
  endtask : t_analog

  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    t_port_b();
    t_wake();
    t_roles();
    t_bidir();
    t_analog();
    print_verdict();
  end
endmodule : nibble_ports_b_c_e_ce_test
`default_nettype wire
